/* pwt_channel.v */
// compare/capture channel 3 of a 16-bit pwm timer with wishbone registers
`timescale 1ns/1ns
module pwt_channel (
    // clock, reset, enable
    input wire clk_i,
    input wire rst_i,
    input wire ce_i,
    // wishbone slave
    input wire cyc_i,
    input wire stb_i,
    input wire we_i,
    input wire [17:0] adr_i,
    input wire [3:0] sel_i,
    input wire [31:0] dat_i,
    output reg [31:0] dat_o,
    output reg ack_o,
    output wire err_o,
    // source tick and capture pins
    input wire src_tick_i,
    input wire cap_a_pin_i,
    input wire cap_b_pin_i,
    // timer outputs and interrupt
    output reg timer_output_a_o,
    output reg timer_output_b_o,
    output wire irq_o
);
`include "pwt_consts.vh"

    ////////////////////////////////////////////////////////////////////////////
    // registers
    reg [15:0] ccctl_r;
    reg [15:0] val_a_r;
    reg [15:0] val_b_r;
    reg [15:0] cnt_r;
    reg [`PWT_IRQ_W-1:0] ien_r;
    reg [`PWT_IRQ_W-1:0] iflg_r;
    reg [7:0] clkctl_r;
    reg [`PWT_PRESC_W-1:0] presc_r;
    reg cap_a_full_r;
    reg cap_b_full_r;
    reg out_a_r;
    reg out_b_r;

    function sel_hit;
        input [17:0] adr;
        input [15:0] idx;
        begin
            sel_hit = (adr == {idx, 2'b00});
        end
    endfunction

    function [15:0] lanes16;
        input [15:0] old;
        input [15:0] wd;
        input [1:0] be;
        begin
            lanes16 = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
        end
    endfunction

    function [15:0] tick_mask;
        input [3:0] code;
        begin
            tick_mask = (16'h0001 << code) - 16'h0001;
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // bus decode
    wire req = cyc_i & stb_i & ~ack_o;
    wire hit_cnt = sel_hit(adr_i, `PWT_IDX_COUNTER);
    wire hit_ctl = sel_hit(adr_i, `PWT_IDX_CCCTL);
    wire hit_a = sel_hit(adr_i, `PWT_IDX_VAL_A);
    wire hit_b = sel_hit(adr_i, `PWT_IDX_VAL_B);
    wire hit_ien = sel_hit(adr_i, `PWT_IDX_IEN);
    wire hit_flg = sel_hit(adr_i, `PWT_IDX_IFLG);
    wire hit_clk = sel_hit(adr_i, `PWT_IDX_CLKCTL);
    wire hit_any = hit_cnt | hit_ctl | hit_a | hit_b | hit_ien | hit_flg | hit_clk;
    wire wr = req & we_i & ce_i;
    wire rd = req & ~we_i & ce_i;
    assign err_o = 1'b0;

    ////////////////////////////////////////////////////////////////////////////
    // count clock prescaler and counter
    wire cnt_en = clkctl_r[`PWT_CNT_EN];
    wire [3:0] div_code = clkctl_r[`PWT_DIV_HI:`PWT_DIV_LO];
    wire [15:0] pmask = tick_mask(div_code);
    wire cnt_tick = cnt_en & src_tick_i & ce_i &
        (({1'b0, presc_r} & pmask) == pmask);

    wire a_cap_mode = ccctl_r[`PWT_A_CAPMD];
    wire b_cap_mode = ccctl_r[`PWT_B_CAPMD];
    wire cmp_a = cnt_tick & ~a_cap_mode & (cnt_r == val_a_r);
    wire cmp_b = cnt_tick & ~b_cap_mode & (cnt_r == val_b_r);

    ////////////////////////////////////////////////////////////////////////////
    // capture edge detectors
    wire trig_a;
    wire trig_b;
    pwt_edge_det u_edge_a (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .pin_i(cap_a_pin_i),
        .sel_i(ccctl_r[`PWT_A_EDGE_HI:`PWT_A_EDGE_LO]),
        .trig_o(trig_a)
    );
    pwt_edge_det u_edge_b (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .pin_i(cap_b_pin_i),
        .sel_i(ccctl_r[`PWT_B_EDGE_HI:`PWT_B_EDGE_LO]),
        .trig_o(trig_b)
    );
    wire cap_a = trig_a & a_cap_mode;
    wire cap_b = trig_b & b_cap_mode;
    wire rd_a = rd & hit_a;
    wire rd_b = rd & hit_b;

    ////////////////////////////////////////////////////////////////////////////
    // interrupt events and flags
    wire [`PWT_IRQ_W-1:0] ev;
    assign ev[`PWT_F_CMPA] = cmp_a;
    assign ev[`PWT_F_CMPB] = cmp_b;
    assign ev[`PWT_F_CAPA] = cap_a;
    assign ev[`PWT_F_CAPB] = cap_b;
    assign ev[`PWT_F_OVRA] = cap_a & cap_a_full_r & ~rd_a;
    assign ev[`PWT_F_OVRB] = cap_b & cap_b_full_r & ~rd_b;
    wire [`PWT_IRQ_W-1:0] clr = (wr & hit_flg & sel_i[0]) ?
        dat_i[`PWT_IRQ_W-1:0] : {`PWT_IRQ_W{1'b0}};
    wire [`PWT_IRQ_W-1:0] iflg_nxt = (iflg_r & ~clr) | ev;
    assign irq_o = |(iflg_r & ien_r);

    ////////////////////////////////////////////////////////////////////////////
    // timer outputs
    wire [1:0] omd_a = ccctl_r[`PWT_A_OMD_HI:`PWT_A_OMD_LO];
    wire [1:0] omd_b = ccctl_r[`PWT_B_OMD_HI:`PWT_B_OMD_LO];

    function out_step;
        input [1:0] md;
        input cur;
        input ca;
        input cb;
        begin
            case (md)
                `PWT_OMD_OFF: out_step = 1'b0;
                `PWT_OMD_SETRST: out_step = ca ? 1'b1 : (cb ? 1'b0 : cur);
                `PWT_OMD_TGLA: out_step = ca ? ~cur : cur;
                `PWT_OMD_TGLB: out_step = cb ? ~cur : cur;
                default: out_step = 1'b0;
            endcase
        end
    endfunction

    wire out_a_nxt = out_step(omd_a, out_a_r, cmp_a, cmp_b);
    wire out_b_nxt = out_step(omd_b, out_b_r, cmp_a, cmp_b);

    ////////////////////////////////////////////////////////////////////////////
    // read data select
    reg [31:0] rd_word;
    always @* begin
        rd_word = `PWT_ZERO32;
        if (hit_cnt) begin
            rd_word = {`PWT_ZERO16, cnt_r};
        end
        if (hit_ctl) begin
            rd_word = {`PWT_ZERO16, ccctl_r};
        end
        if (hit_a) begin
            rd_word = {`PWT_ZERO16, val_a_r};
        end
        if (hit_b) begin
            rd_word = {`PWT_ZERO16, val_b_r};
        end
        if (hit_ien) begin
            rd_word = {{(32-`PWT_IRQ_W){1'b0}}, ien_r};
        end
        if (hit_flg) begin
            rd_word = {{(32-`PWT_IRQ_W){1'b0}}, iflg_r};
        end
        if (hit_clk) begin
            rd_word = {24'h00_0000, clkctl_r & `PWT_CLKCTL_RD_MASK};
        end
        if (~hit_any) begin
            rd_word = `PWT_ZERO32;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // bus answer, one wait-free cycle
    always @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            dat_o <= `PWT_ZERO32;
        end else if (ce_i) begin
            ack_o <= req;
            if (rd) begin
                dat_o <= rd_word;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // count clock control, prescaler and counter
    always @(posedge clk_i) begin
        if (rst_i) begin
            clkctl_r <= `PWT_CLKCTL_RST;
            presc_r <= {`PWT_PRESC_W{1'b0}};
            cnt_r <= `PWT_ZERO16;
        end else if (ce_i) begin
            if (cnt_en & src_tick_i) begin
                presc_r <= presc_r + {{(`PWT_PRESC_W-1){1'b0}}, 1'b1};
            end
            if (cnt_tick) begin
                cnt_r <= (cnt_r == `PWT_CNT_MAX) ? `PWT_ZERO16 : cnt_r + 16'h0001;
            end
            if (wr & hit_clk & sel_i[0]) begin
                clkctl_r <= dat_i[7:0];
                presc_r <= {`PWT_PRESC_W{1'b0}};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // control and enable registers
    always @(posedge clk_i) begin
        if (rst_i) begin
            ccctl_r <= `PWT_ZERO16;
            ien_r <= {`PWT_IRQ_W{1'b0}};
        end else if (ce_i) begin
            if (wr & hit_ctl) begin
                ccctl_r <= lanes16(ccctl_r, dat_i[15:0], sel_i[1:0]) & `PWT_CCCTL_MASK;
            end
            if (wr & hit_ien & sel_i[0]) begin
                ien_r <= dat_i[`PWT_IRQ_W-1:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // value registers, a capture wins over a bus write in the same cycle
    always @(posedge clk_i) begin
        if (rst_i) begin
            val_a_r <= `PWT_ZERO16;
            cap_a_full_r <= 1'b0;
        end else if (ce_i) begin
            if (cap_a) begin
                val_a_r <= cnt_r;
                cap_a_full_r <= 1'b1;
            end else begin
                if (wr & hit_a) begin
                    val_a_r <= lanes16(val_a_r, dat_i[15:0], sel_i[1:0]);
                end
                if (rd_a) begin
                    cap_a_full_r <= 1'b0;
                end
            end
        end
    end
    always @(posedge clk_i) begin
        if (rst_i) begin
            val_b_r <= `PWT_ZERO16;
            cap_b_full_r <= 1'b0;
        end else if (ce_i) begin
            if (cap_b) begin
                val_b_r <= cnt_r;
                cap_b_full_r <= 1'b1;
            end else begin
                if (wr & hit_b) begin
                    val_b_r <= lanes16(val_b_r, dat_i[15:0], sel_i[1:0]);
                end
                if (rd_b) begin
                    cap_b_full_r <= 1'b0;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // flags and timer outputs
    always @(posedge clk_i) begin
        if (rst_i) begin
            iflg_r <= {`PWT_IRQ_W{1'b0}};
            out_a_r <= 1'b0;
            out_b_r <= 1'b0;
            timer_output_a_o <= 1'b0;
            timer_output_b_o <= 1'b0;
        end else if (ce_i) begin
            iflg_r <= iflg_nxt;
            out_a_r <= out_a_nxt;
            out_b_r <= out_b_nxt;
            timer_output_a_o <= out_a_nxt ^ ccctl_r[`PWT_A_INV];
            timer_output_b_o <= out_b_nxt ^ ccctl_r[`PWT_B_INV];
        end
    end
endmodule // pwt_channel

/* pwt_channel_asserts.sv */
// port checks for the compare/capture channel
`timescale 1ns/1ns
`include "pwt_consts.vh"
module pwt_channel_asserts (
    // clock and reset
    input wire clk_i,
    input wire rst_i,
    input wire ce_i,
    // bus
    input wire cyc_i,
    input wire stb_i,
    input wire we_i,
    input wire [17:0] adr_i,
    input wire [31:0] dat_o,
    input wire ack_o,
    input wire err_o,
    // outputs
    input wire timer_output_a_o,
    input wire timer_output_b_o,
    input wire irq_o
);
    wire rd_ctl = cyc_i && !we_i && adr_i == {`PWT_IDX_CCCTL, 2'b00};
    wire rd_flg = cyc_i && !we_i && adr_i == {`PWT_IDX_IFLG, 2'b00};
    wire [3:0] outs = {ack_o, irq_o, timer_output_a_o, timer_output_b_o};
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence req_s;
        cyc_i && stb_i && !ack_o && ce_i;
    endsequence
    sequence ans_s;
        ack_o ##1 !ack_o;
    endsequence
    ack_resp_a: assert property (req_s |=> ans_s) else $error("no single ack");
    ack_cause_a: assert property (ack_o |-> $past(cyc_i) && $past(stb_i)) else $error("stray ack");
    err_zero_a: assert property (!err_o) else $error("err raised");
    reset_clear_a: assert property ($fell(rst_i) |-> outs == 4'h0) else $error("reset");
    irq_fall_a: assert property ($fell(irq_o) |-> ack_o && $past(we_i))
        else $error("irq fell without write");
    freeze_hold_a: assert property (!ce_i |=> $stable(outs)) else $error("moved while frozen");
    flag_read_a: assert property (ack_o && $past(rd_flg) |-> (dat_o & 32'hffff_ffc0) == 0)
        else $error("flag reserved bits");
    ctl_read_a: assert property (ack_o && $past(rd_ctl) |-> (dat_o & 32'hffff_0c0c) == 0)
        else $error("ctl reserved bits");
endmodule // pwt_channel_asserts
bind pwt_channel pwt_channel_asserts u_chk (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
    .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .dat_o(dat_o), .ack_o(ack_o),
    .err_o(err_o), .timer_output_a_o(timer_output_a_o), .timer_output_b_o(timer_output_b_o),
    .irq_o(irq_o));

/* pwt_consts.vh */
// constants for the pwm timer compare/capture channel
`ifndef PWT_CONSTS_VH
`define PWT_CONSTS_VH
// register offsets (byte addresses are index * 4)
`define PWT_IDX_COUNTER 16'h5462
`define PWT_IDX_CCCTL 16'h5464
`define PWT_IDX_VAL_A 16'h5466
`define PWT_IDX_VAL_B 16'h5468
`define PWT_IDX_IEN 16'h546a
`define PWT_IDX_IFLG 16'h546c
`define PWT_IDX_CLKCTL 16'h506b
// control register fields
`define PWT_B_EDGE_HI 15
`define PWT_B_EDGE_LO 14
`define PWT_B_OMD_HI 13
`define PWT_B_OMD_LO 12
`define PWT_B_INV 9
`define PWT_B_CAPMD 8
`define PWT_A_EDGE_HI 7
`define PWT_A_EDGE_LO 6
`define PWT_A_OMD_HI 5
`define PWT_A_OMD_LO 4
`define PWT_A_INV 1
`define PWT_A_CAPMD 0
`define PWT_CCCTL_MASK 16'hf3f3
// interrupt bits
`define PWT_IRQ_W 6
`define PWT_IRQ_MASK 16'h003f
`define PWT_F_CMPA 0
`define PWT_F_CMPB 1
`define PWT_F_CAPA 2
`define PWT_F_CAPB 3
`define PWT_F_OVRA 4
`define PWT_F_OVRB 5
// edge codes
`define PWT_EDGE_NONE 2'h0
`define PWT_EDGE_RISE 2'h1
`define PWT_EDGE_FALL 2'h2
`define PWT_EDGE_BOTH 2'h3
// output modes
`define PWT_OMD_OFF 2'h0
`define PWT_OMD_SETRST 2'h1
`define PWT_OMD_TGLA 2'h2
`define PWT_OMD_TGLB 2'h3
// divider
`define PWT_DIV_HI 7
`define PWT_DIV_LO 4
`define PWT_CNT_EN 0
`define PWT_PRESC_W 15
`define PWT_ZERO16 16'h0000
`define PWT_ZERO32 32'h0000_0000
`define PWT_CLKCTL_RST 8'h00
`define PWT_CLKCTL_RD_MASK 8'hf1
`define PWT_CNT_MAX 16'hffff
`endif

/* pwt_edge_det.v */
// two-stage synchroniser with edge select for one capture pin
`timescale 1ns/1ns
module pwt_edge_det (
    // clock and reset
    input wire clk_i,
    input wire rst_i,
    input wire ce_i,
    // pin and select
    input wire pin_i,
    input wire [1:0] sel_i,
    // capture strobe
    output wire trig_o
);
`include "pwt_consts.vh"
    reg s1_r;
    reg s2_r;
    reg s3_r;
    always @(posedge clk_i) begin
        if (rst_i) begin
            s1_r <= 1'b0;
            s2_r <= 1'b0;
            s3_r <= 1'b0;
        end else if (ce_i) begin
            s1_r <= pin_i;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end
    wire rise = s2_r & ~s3_r;
    wire fall = ~s2_r & s3_r;
    assign trig_o = ce_i & (((sel_i == `PWT_EDGE_RISE) & rise) |
        ((sel_i == `PWT_EDGE_FALL) & fall) | ((sel_i == `PWT_EDGE_BOTH) & (rise | fall)));
endmodule // pwt_edge_det

/* pwt_pins.sv */
// capture pin driver and timer output edge counter
`timescale 1ns/1ns
module pwt_pins (
    // clock
    input wire clk_i,
    // capture pins
    output logic cap_a_o,
    output logic cap_b_o,
    // timer output
    input wire tmr_a_i
);
    int edges_a = 0;
    initial begin
        cap_a_o = 1'b0;
        cap_b_o = 1'b0;
    end
    task automatic set_pins(input logic a, input logic b);
        @(posedge clk_i);
        cap_a_o <= a;
        cap_b_o <= b;
    endtask
    always @(tmr_a_i) edges_a++;
endmodule // pwt_pins

/* testbench.sv */
// self-checking bench for the compare/capture channel
`timescale 1ns/1ns
`include "pwt_consts.vh"
`define CHK(nm, ex, got) begin \
    cmp_count++; \
    if ((got) !== (ex)) begin \
        fail_count++; \
        $display("mismatch %s exp %h got %h", nm, ex, got); \
    end \
end
module testbench;
    localparam logic [17:0] a_cnt = {`PWT_IDX_COUNTER, 2'b00};
    localparam logic [17:0] a_ctl = {`PWT_IDX_CCCTL, 2'b00};
    localparam logic [17:0] a_va = {`PWT_IDX_VAL_A, 2'b00};
    localparam logic [17:0] a_vb = {`PWT_IDX_VAL_B, 2'b00};
    localparam logic [17:0] a_ien = {`PWT_IDX_IEN, 2'b00};
    localparam logic [17:0] a_flg = {`PWT_IDX_IFLG, 2'b00};
    localparam logic [17:0] a_clk = {`PWT_IDX_CLKCTL, 2'b00};
    logic clk_i = 0, rst_i = 1, ce_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, src_tick_i = 1;
    logic [17:0] adr_i = 0;
    logic [3:0] sel_i = 0;
    logic [31:0] dat_i = 0, rdata;
    wire [31:0] dat_o;
    wire ack_o, err_o, cap_a, cap_b, tmr_a, tmr_b, irq_o;
    int fail_count = 0, cmp_count = 0, e0;
    pwt_channel dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .cyc_i(cyc_i), .stb_i(stb_i),
        .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .err_o(err_o), .src_tick_i(src_tick_i), .cap_a_pin_i(cap_a), .cap_b_pin_i(cap_b),
        .timer_output_a_o(tmr_a), .timer_output_b_o(tmr_b), .irq_o(irq_o));
    pwt_pins pins (.clk_i(clk_i), .cap_a_o(cap_a), .cap_b_o(cap_b), .tmr_a_i(tmr_a));
    initial forever #10 clk_i = ~clk_i;
    task automatic results;
        if (fail_count == 0 && cmp_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic bus(input logic w, input logic [17:0] a, input logic [15:0] d);
        @(posedge clk_i);
        {cyc_i, stb_i, we_i, sel_i, adr_i, dat_i} <= {2'b11, w, 4'h3, a, 16'h0000, d};
        @(posedge clk_i);
        while (ack_o !== 1'b1) @(posedge clk_i);
        rdata = dat_o;
        {cyc_i, stb_i, we_i} <= 3'b000;
    endtask
    task automatic rc(input string nm, input logic [17:0] a, input logic [15:0] ex);
        bus(0, a, 0);
        `CHK(nm, {16'h0000, ex}, rdata)
    endtask
    task automatic wait_n(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    task automatic do_reset;
        rst_i <= 1;
        wait_n(20);
        rst_i <= 0;
    endtask
    task automatic t_regs;
        logic [17:0] al[7] = '{a_cnt, a_ctl, a_va, a_vb, a_ien, a_flg, 18'h1_5300};
        foreach (al[i]) rc("reset", al[i], 16'h0000);
        bus(1, a_cnt, 16'h1234);
        rc("counter", a_cnt, 16'h0000);
        bus(1, a_ctl, 16'hffff);
        rc("ctl", a_ctl, 16'hf3f3);
        bus(1, a_ien, 16'hffff);
        rc("ien", a_ien, 16'h003f);
        bus(1, a_ien, 16'h0000);
        bus(1, a_ctl, 16'h0202);
        wait_n(3);
        `CHK("invert", 2'b11, {tmr_a, tmr_b})
        ce_i <= 0;
        wait_n(3);
        ce_i <= 1;
        bus(1, a_ctl, 16'h0000);
    endtask
    task automatic t_compare;
        bus(1, a_va, 16'h0040);
        bus(1, a_vb, 16'h0080);
        bus(1, a_ien, 16'h0003);
        bus(1, a_ctl, 16'h3010);
        e0 = pins.edges_a;
        bus(1, a_clk, 16'h0001);
        wait_n(200);
        rc("cmp flags", a_flg, 16'h0003);
        `CHK("timer_output", {e0 + 2, 2'b01}, {pins.edges_a, tmr_a, tmr_b})
        `CHK("irq", 1'b1, irq_o)
        bus(1, a_flg, 16'h0001);
        rc("w1c", a_flg, 16'h0002);
        bus(1, a_flg, 16'h0002);
        `CHK("irq off", 1'b0, irq_o)
    endtask
    task automatic t_div;
        int c0;
        bus(1, a_clk, 16'h0021);
        bus(0, a_cnt, 0);
        c0 = rdata;
        wait_n(37);
        rc("div", a_cnt, 16'(c0 + 10));
    endtask
    task automatic t_capture;
        for (int c = 0; c < 4; c++) begin
            bus(1, a_ctl, 16'(c * 16'h4040 + 16'h0101));
            for (int l = 1; l >= 0; l--) begin
                pins.set_pins(l[0], l[0]);
                wait_n(8);
                rc("edge", a_flg, c[1 - l] ? 16'h000c : 16'h0000);
                bus(0, a_va, 0);
                bus(0, a_vb, 0);
                bus(1, a_flg, 16'h003f);
            end
        end
    endtask
    task automatic t_overrun;
        bus(1, a_ctl, 16'h0041);
        bus(1, a_ien, 16'h0010);
        bus(1, a_clk, 16'h0001);
        bus(1, a_clk, 16'h0000);
        bus(1, a_flg, 16'h003f);
        for (int k = 0; k < 3; k++) begin
            pins.set_pins(~k[0], ~k[0]);
            wait_n(8);
        end
        rc("overrun", a_flg, 16'h0014);
        `CHK("irq ovr", 1'b1, irq_o)
        bus(1, a_flg, 16'h0014);
        rc("cleared", a_flg, 16'h0000);
        `CHK("irq clr", 1'b0, irq_o)
        rc("cap value", a_va, 16'h0003);
    endtask
    initial begin
        do_reset();
        t_regs();
        t_compare();
        t_div();
        do_reset();
        t_capture();
        t_overrun();
        results();
    end
    initial begin
        wait_n(20000);
        fail_count++;
        results();
    end
endmodule // testbench
